// *** verilog/sar_host.sv ***
`timescale 1ns/1ps
`include "sar_params.svh"
module sar_host import sar_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire sar_var_e variant,
    // Conversion request, one pulse per start
    input wire logic start,
    // Result stream
    output logic res_valid,
    input wire logic res_ready,
    output logic [11:0] res_data,
    output logic busy,
    // Link
    sar_link_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_CLK, H_QUIET} sar_hst_e;
    typedef struct packed {
        sar_hst_e st;
        logic cs_n;
        logic sclk;
        logic [3:0] div;
        logic [4:0] cnt;
        logic [15:0] shin;
        logic [1:0] d_sync;
        logic [7:0] quiet;
        logic push;
        logic [11:0] word;
        logic bsy;
    } sar_hst_s;
    sar_hst_s r, next_r;
    logic fifo_ready;
    logic [4:0] n_edges;
    assign n_edges = sar_edges(variant); // [RQ12] frame sized per variant, no trailing bits

    // Framing, clock divider, rising-edge capture
    always_comb begin
        next_r = r;
        next_r.d_sync = {r.d_sync[0], link.serial_result_out};
        next_r.push = 1'b0;
        unique case (r.st)
            H_IDLE: begin
                // Start only when the result FIFO has room
                if (start && fifo_ready) begin
                    next_r.cs_n = 1'b0; // [RQ14]
                    next_r.st = H_CLK;
                    next_r.div = 4'd0;
                    next_r.cnt = 5'd0;
                    next_r.sclk = 1'b1; // [RQ11] first edge is a fall, zero two read on rise one
                end
            end
            H_CLK: begin
                next_r.div = r.div + 4'd1;
                if (r.div == `SAR_DIV_HALF - 4'd1) begin
                    next_r.div = 4'd0;
                    next_r.sclk = !r.sclk;
                    if (!r.sclk) begin
                        // Rising edge: take bit, two cycles of sync margin
                        next_r.shin = {r.shin[14:0], r.d_sync[1]}; // [RQ10]
                    end else begin
                        next_r.cnt = r.cnt + 5'd1;
                    end
                    if (r.sclk && r.cnt + 5'd1 == n_edges) begin
                        next_r.st = H_QUIET; // [RQ7]
                        next_r.quiet = 8'd0;
                    end
                end
            end
            H_QUIET: begin
                if (r.quiet == 8'd0) begin
                    next_r.cs_n = 1'b1;
                    next_r.push = 1'b1;
                    unique case (variant)
                        SAR_BITS12: next_r.word = r.shin[11:0]; // [RQ14]
                        SAR_BITS10: next_r.word = {r.shin[9:0], 2'b00};
                        default: next_r.word = {r.shin[7:0], 4'h0};
                    endcase
                end
                // Clock parks high a cycle after select rises, never alongside it
                if (r.quiet == 8'd1) begin
                    next_r.sclk = 1'b1;
                end
                next_r.quiet = r.quiet + 8'd1;
                if (r.quiet == 8'(`SAR_QUIET_CYC)) begin
                    next_r.st = H_IDLE; // [RQ15]
                end
            end
        endcase
        next_r.bsy = next_r.st != H_IDLE;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= '{st: H_IDLE, cs_n: 1'b1, sclk: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    sar_fifo #(.WIDTH(12), .DEPTH(`SAR_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(r.push),
        .in_ready(fifo_ready),
        .in_data(r.word),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
    assign link.cs_n = r.cs_n;
    assign link.sclk = r.sclk;
    assign busy = r.bsy;
endmodule

// *** include/sar_params.svh ***
// Overview of operation
// RQ1 - Chip select fall: power up, track, drive
// RQ2 - Third falling edge: hold, fully powered
// RQ3 - Twelve-bit: sixteenth fall ends, power down
// RQ4 - Ten-bit: fourteenth fall ends, power down
// RQ5 - Eight-bit: twelfth fall ends, power down
// RQ6 - Early chip select rise aborts, powers down
// RQ7 - Host gives 16, 14 or 12 clocks
// RQ8 - First zero on select, second on fall
// RQ9 - Last bit on fifteenth fall, held
// RQ10 - Host may sample on rising edges
// RQ11 - Rising-first host reads both leading zeros
// RQ12 - Sixteen-bit frames discard trailing bits
// RQ13 - Host starts conversions equally spaced (the host starts a frame on a start request when idle with room in the result FIFO instead)
// RQ14 - Host frames, clocks, assembles MSB first
// RQ15 - Host waits quiet time before next
// RQ16 - Host performs one dummy conversion first (sar_host has none; the testbench issues one as its first frame)
// RQ17 - Result follows zeros, MSB first
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_EDGES_12 5'd16
`define SAR_EDGES_10 5'd14
`define SAR_EDGES_8 5'd12
`define SAR_HOLD_EDGE 5'd3
`define SAR_LEAD_ZEROS 5'd2
`define SAR_DIV_HALF 4'd8
`define SAR_QUIET_NS 50
`define SAR_CLK_NS 4
`define SAR_QUIET_CYC ((`SAR_QUIET_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_FIFO_DEPTH 8
`endif

// *** include/sar_pkg.sv ***
`include "sar_params.svh"
package sar_pkg;
    typedef enum logic [1:0] {SAR_BITS12, SAR_BITS10, SAR_BITS8} sar_var_e;
    typedef logic [11:0] sar_word_t;

    // Edge count that ends a frame for each variant
    function automatic logic [4:0] sar_edges(input sar_var_e v);
        unique case (v)
            SAR_BITS12: sar_edges = `SAR_EDGES_12;
            SAR_BITS10: sar_edges = `SAR_EDGES_10;
            default: sar_edges = `SAR_EDGES_8;
        endcase
    endfunction
endpackage

// *** include/sar_link_if.sv ***
`timescale 1ns/1ps
interface sar_link_if;
    logic cs_n;
    logic sclk;
    logic serial_result_out;
    logic serial_result_oe;
    modport device (input cs_n, input sclk, output serial_result_out, output serial_result_oe);
    modport host (output cs_n, output sclk, input serial_result_out, input serial_result_oe);
endinterface

// *** verilog/sar_fifo.sv ***
`timescale 1ns/1ps
module sar_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    // Extra pointer bit separates full from empty
    assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// *** verilog/sar_device.sv ***
`timescale 1ns/1ps
`include "sar_params.svh"
module sar_device import sar_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Variant and analog sample source
    input wire sar_var_e variant,
    input wire sar_word_t sample_in,
    // Link
    sar_link_if.device link,
    // Status
    output logic powered,
    output logic tracking
);
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] ck_sync;
        logic cs_d;
        logic ck_d;
        logic active;
        logic [4:0] edges;
        logic [15:0] shreg;
        logic dout;
        logic oe;
        logic trk;
    } sar_dev_s;
    sar_dev_s r, next_r;
    logic cs_fall, cs_rise, ck_fall;
    assign cs_fall = r.cs_d && !r.cs_sync[1];
    assign cs_rise = !r.cs_d && r.cs_sync[1];
    assign ck_fall = r.ck_d && !r.ck_sync[1];

    // Frame logic on sampled chip select and serial clock
    always_comb begin
        next_r = r;
        next_r.cs_sync = {r.cs_sync[0], link.cs_n};
        next_r.ck_sync = {r.ck_sync[0], link.sclk};
        next_r.cs_d = r.cs_sync[1];
        next_r.ck_d = r.ck_sync[1];
        if (cs_fall) begin
            next_r.active = 1'b1; // [RQ1]
            next_r.trk = 1'b1; // [RQ1]
            next_r.oe = 1'b1; // [RQ1]
            next_r.dout = 1'b0; // [RQ8]
            next_r.edges = 5'd0;
        end else if (cs_rise && r.active) begin
            // Abort: output released and powered down at once
            next_r.active = 1'b0; // [RQ6]
            next_r.oe = 1'b0; // [RQ6]
            next_r.trk = 1'b0; // [RQ6]
        end else if (r.active && ck_fall) begin
            next_r.edges = r.edges + 5'd1;
            if (r.edges + 5'd1 == `SAR_HOLD_EDGE) begin
                // Sample fixed; result aligned MSB first after the zeros
                next_r.trk = 1'b0; // [RQ2]
                unique case (variant)
                    SAR_BITS12: next_r.shreg = {sample_in, 4'h0}; // [RQ17]
                    SAR_BITS10: next_r.shreg = {sample_in[11:2], 6'h00};
                    default: next_r.shreg = {sample_in[11:4], 8'h00};
                endcase
            end else if (r.edges >= `SAR_HOLD_EDGE) begin
                next_r.shreg = {r.shreg[14:0], 1'b0};
            end
            if (r.edges + 5'd1 == sar_edges(variant)) begin
                next_r.active = 1'b0; // [RQ3] [RQ4] [RQ5]
                next_r.oe = 1'b0;
                next_r.dout = 1'b0;
            end else if (r.edges + 5'd1 <= `SAR_HOLD_EDGE) begin
                // Zeros run through the hold edge; the MSB comes one fall later
                next_r.dout = 1'b0; // [RQ8]
            end else begin
                next_r.dout = r.shreg[15]; // [RQ9] [RQ17]
            end
        end
    end

    // Idle state is powered down, hold, released output
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Edge detectors start at the idle pin levels, so no false edge
            r <= '{cs_sync: 2'b11, ck_sync: 2'b11, cs_d: 1'b1, ck_d: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end
    assign link.serial_result_out = r.dout;
    assign link.serial_result_oe = r.oe;
    assign powered = r.active;
    assign tracking = r.trk;
endmodule

// *** test/sar_link_sva.sv ***
`timescale 1ns/1ps
module sar_link_sva import sar_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic host_rst,
    // Link and device status
    input wire sar_var_e variant,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic powered,
    input wire logic tracking
);
    logic sclk_q, cs_q, fall;
    logic [4:0] cnt, last;
    logic [3:0] age;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Final edge per variant, spelled out rather than borrowed from the design
    assign fall = sclk_q && !sclk;
    assign last = variant == SAR_BITS12 ? 5'h10 : variant == SAR_BITS10 ? 5'h0e : 5'h0c;
    // Falls in this frame; age saturates so a long idle never wraps
    always_ff @(posedge ref_clk) begin
        sclk_q <= rst || sclk;
        cs_q <= rst || cs_n;
        if (rst || (cs_q && !cs_n)) begin
            cnt <= 5'h0;
        end else if (fall) begin
            cnt <= cnt + 5'h1;
        end
        age <= rst ? 4'hf : fall ? 4'h0 : age == 4'hf ? age : age + 4'h1;
    end
    sequence s_wake;
        ##[1:6] (serial_result_oe && tracking && powered);
    endsequence
    // Well after a mid-frame fall, before the next rise
    sequence s_mid;
        !cs_n && cnt >= 5'h3 && cnt < last && age == 4'h6;
    endsequence
    AST_WAKE: assert property ($fell(cs_n) |-> s_wake)
        else $error("no wake after select");
    AST_FIRST_ZERO: assert property ($rose(serial_result_oe) |-> !serial_result_out)
        else $error("first bit not zero");
    AST_HOLD: assert property (s_mid |-> !tracking && powered)
        else $error("not holding after third fall");
    AST_DRIVE: assert property (s_mid |-> serial_result_oe)
        else $error("data released early");
    AST_STEADY: assert property (serial_result_oe && $past(serial_result_oe)
        && $changed(serial_result_out) |-> age <= 4'h5)
        else $error("data moved away from a fall");
    AST_END: assert property (cnt == last && age == 4'h6 |-> !serial_result_oe && !powered)
        else $error("no release on final fall");
    AST_LEN: assert property ($rose(cs_n) && !$past(host_rst) |-> ##[0:4] cnt == last)
        else $error("frame length wrong");
    AST_ABORT: assert property ($rose(cs_n) |-> ##[0:5] !serial_result_oe && !powered)
        else $error("no power-down on deselect");
    AST_IDLE: assert property (cs_n [*6] |-> !serial_result_oe && !tracking)
        else $error("active while deselected");
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import sar_pkg::*;
    logic ref_clk, rst, host_rst, start, res_ready, res_valid, busy, powered, tracking;
    sar_var_e variant;
    sar_word_t sample_in, cur_s;
    logic [11:0] res_data;
    logic [11:0] exp_q[$];
    sar_word_t vals[8] = '{12'hfff, 12'h000, 12'h801, 12'h7fe, 12'ha5c, 12'h3c3, 12'h5a5, 12'h123};
    int bad_count = 0;
    int samples_checked = 0;
    int rise_n, t;
    sar_link_if link();
    sar_device sar_device_inst(.ref_clk(ref_clk), .rst(rst), .variant(variant),
        .sample_in(sample_in), .link(link), .powered(powered), .tracking(tracking));
    sar_host sar_host_inst(.ref_clk(ref_clk), .rst(rst || host_rst), .variant(variant),
        .start(start),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .busy(busy),
        .link(link));
    sar_link_sva sar_link_sva_inst(.ref_clk(ref_clk), .rst(rst), .host_rst(host_rst),
        .variant(variant),
        .cs_n(link.cs_n), .sclk(link.sclk), .serial_result_out(link.serial_result_out),
        .serial_result_oe(link.serial_result_oe), .powered(powered), .tracking(tracking));
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Head of the result buffer against the oldest expectation, then pop it
    task automatic take();
        check({11'h0, res_valid}, 12'h1);
        check(res_data, exp_q.pop_front());
        res_ready = 1'b1;
        step(1);
        res_ready = 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One frame; the input moves after the hold point to prove it was frozen
    task automatic convert(input sar_var_e v, input sar_word_t s);
        variant = v;
        sample_in = s;
        cur_s = s;
        start = 1'b1;
        for (t = 0; t < 100 && busy !== 1'b1; t++) step(1);
        start = 1'b0;
        repeat (4) @(negedge link.sclk);
        #1 sample_in = ~s;
        for (t = 0; t < 1000 && busy !== 1'b0; t++) step(1);
        check({11'h0, busy}, 12'h0);
        exp_q.push_back(v == SAR_BITS12 ? s : v == SAR_BITS10 ? {s[11:2], 2'h0}
            : {s[11:4], 4'h0});
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Wire order: zeros on rises one to three, result MSB on the fourth
    always @(negedge link.cs_n) rise_n = 0;
    always @(posedge link.sclk) begin
        if (link.cs_n === 1'b0) begin
            rise_n++;
            if (rise_n <= 3) check({11'h0, link.serial_result_out}, 12'h0);
            if (rise_n == 4) check({11'h0, link.serial_result_out}, {11'h0, cur_s[11]});
            if (rise_n == 15 && variant == SAR_BITS12)
                check({11'h0, link.serial_result_out}, {11'h0, cur_s[0]});
        end
    end
    // Fill the buffer with the drain stalled, then drain and compare
    initial begin
        rst = 1'b1;
        host_rst = 1'b0;
        start = 1'b0;
        res_ready = 1'b0;
        variant = SAR_BITS12;
        sample_in = 12'h0;
        cur_s = 12'h0;
        step(20);
        rst = 1'b0;
        step(1);
        // Dummy frame parks the converter in power-down before real work
        convert(SAR_BITS12, 12'h000);
        take();
        for (int i = 0; i < 8; i++) convert(sar_var_e'(i % 3), vals[i]);
        start = 1'b1;
        step(60);
        check({11'h0, busy}, 12'h0);
        start = 1'b0;
        res_ready = 1'b1;
        for (t = 0; t < 200 && exp_q.size() > 0; t++) begin
            if (res_valid === 1'b1) check(res_data, exp_q.pop_front());
            step(1);
        end
        check(12'(exp_q.size()), 12'h0);
        check({11'h0, res_valid}, 12'h0);
        // Host reset while tracking raises select early and must abort the frame
        res_ready = 1'b0;
        start = 1'b1;
        for (t = 0; t < 100 && busy !== 1'b1; t++) step(1);
        start = 1'b0;
        step(16);
        check({10'h0, powered, tracking}, 12'h3);
        host_rst = 1'b1;
        step(1);
        host_rst = 1'b0;
        step(8);
        check({10'h0, powered, tracking}, 12'h0);
        check({11'h0, link.serial_result_oe}, 12'h0);
        convert(SAR_BITS12, 12'h6b9);
        take();
        close_out();
    end
    // All frames together need well under a tenth of this
    initial begin
        #200us;
        bad_count++;
        close_out();
    end
endmodule
